// ---- hw/spms_map.svh ----
// register offsets, field positions, reset values and clock-rate reloads of the serial port
`ifndef SPMS_MAP_SVH
`define SPMS_MAP_SVH

// register byte offsets
`define SPMS_OFF_CTRL    8'h2C
`define SPMS_OFF_STAT    8'h30
`define SPMS_OFF_DATA    8'h34
`define SPMS_OFF_PINDIR  8'h38

// port_control_reg fields
`define SPMS_CTRL_IE     7
`define SPMS_CTRL_EN     6
`define SPMS_CTRL_ORD    5
`define SPMS_CTRL_MASTER_SELECT_BIT   4
`define SPMS_CTRL_CLOCK_IDLE_LEVEL   3
`define SPMS_CTRL_CLOCK_PHASE_SEL   2
`define SPMS_CTRL_RATE_H 1
`define SPMS_CTRL_RATE_L 0
`define SPMS_CTRL_RST    8'h00

// port_status_reg fields
`define SPMS_STAT_DONE   7
`define SPMS_STAT_WRITE_COLLISION_FLAG   6
`define SPMS_STAT_DBL    0

// pin direction register fields
`define SPMS_DIR_MOSI    0
`define SPMS_DIR_SCK     1
`define SPMS_DIR_SS      2
`define SPMS_DIR_MISO    3
`define SPMS_DIR_SSLVL   4
`define SPMS_DIR_RST     5'h00

// bit counter value of the last bit of a byte
`define SPMS_BIT_LAST    4'h7

// half-period reload per divisor (half period minus one, in core_clk cycles)
`define SPMS_HALF_D2     7'h00
`define SPMS_HALF_D4     7'h01
`define SPMS_HALF_D8     7'h03
`define SPMS_HALF_D16    7'h07
`define SPMS_HALF_D32    7'h0F
`define SPMS_HALF_D64    7'h1F
`define SPMS_HALF_D128   7'h3F

`endif

// ---- hw/spms_pkg.sv ----
// types shared by the serial port design
package spms_pkg;

    // master clock generator phase, gray along idle -> lead -> trail
    typedef enum logic [1:0] {
        SPMS_PH_IDLE  = 2'b00,
        SPMS_PH_LEAD  = 2'b01,
        SPMS_PH_TRAIL = 2'b11
    } spms_phase_t;

    // serial pin levels seen by the port
    typedef struct packed {
        logic sck_i;
        logic mosi_i;
        logic miso_i;
        logic slave_sel_n_i;
    } spms_pin_in_t;

    // serial pin drive, each enable low while driving
    typedef struct packed {
        logic sck_o;
        logic sck_oe_n;
        logic mosi_o;
        logic mosi_oe_n;
        logic miso_o;
        logic miso_oe_n;
        logic slave_sel_n_o;
        logic slave_sel_oe_n;
    } spms_pin_out_t;

    // complete state of the port
    typedef struct packed {
        logic [7:0]    ctrl;
        logic          dbl;
        logic          done;
        logic          write_collision_flag;
        logic          armed;
        logic [4:0]    dir;
        logic [7:0]    rx_buf;
        logic [7:0]    tx_sh;
        logic [7:0]    rx_sh;
        logic [3:0]    cnt;
        logic [6:0]    div;
        spms_phase_t   phase;
        logic          xfer_on;
        logic          sck_lvl;
        logic          sck_prev;
        logic [31:0]   prdata;
        logic          pready;
        logic          pslverr;
        logic          irq;
        spms_pin_out_t pins;
    } spms_state_t;

endpackage : spms_pkg

// ---- hw/spms_port.sv ----
// byte-wide serial port, master or slave, with apb register access
`timescale 1ns/1ps
`include "spms_map.svh"
module spms_port #(
    parameter int ADDR_W = 8
) (
    // clock and reset
    input  wire logic                  core_clk,
    input  wire logic                  sys_rst,
    // apb slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [ADDR_W-1:0]     paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    // cpu interrupt side
    input  wire logic                  global_irq_en,
    input  wire logic                  irq_vector_taken,
    output logic                       irq_req,
    // serial pins
    input  spms_pkg::spms_pin_in_t     pin_in,
    output spms_pkg::spms_pin_out_t    pin_out
);

    // refuse address widths that cannot hold the map
    if (ADDR_W < 6 || ADDR_W > 32) begin : g_bad_addr
        $error("spms_port: ADDR_W must be 6 to 32");
    end

    spms_pkg::spms_state_t s_ff;
    spms_pkg::spms_state_t nxt_s;

    logic       en;
    logic       mst;
    logic       slv;
    logic       clock_idle_level;
    logic       clock_phase_sel;
    logic       lsb;
    logic       forced;
    logic       m_tick;
    logic       s_edge;
    logic       lead;
    logic       trail;
    logic       sample;
    logic       setup;
    logic       last;
    logic       rx_in;
    logic       acc;
    logic       issue;
    logic       hit;
    logic       sel_ctrl;
    logic       sel_stat;
    logic       sel_data;
    logic       sel_dir;
    logic       data_wr;
    logic       start;
    logic       set_done;
    logic       clr_flags;
    logic [6:0] half;
    logic [7:0] rx_next;
    logic [7:0] rd_mux;

    // rate table: divisor half-period reload
    function automatic logic [6:0] half_of(input logic [2:0] code);
        logic [6:0] h;
        h = `SPMS_HALF_D4;
        unique case (code)
            3'h0: h = `SPMS_HALF_D4;
            3'h1: h = `SPMS_HALF_D16;
            3'h2: h = `SPMS_HALF_D64;
            3'h3: h = `SPMS_HALF_D128;
            3'h4: h = `SPMS_HALF_D2;
            3'h5: h = `SPMS_HALF_D8;
            3'h6: h = `SPMS_HALF_D32;
            3'h7: h = `SPMS_HALF_D64;
        endcase
        return h;
    endfunction : half_of

    // mode decode
    assign en     = s_ff.ctrl[`SPMS_CTRL_EN];
    assign mst    = en & s_ff.ctrl[`SPMS_CTRL_MASTER_SELECT_BIT];
    assign slv    = en & ~s_ff.ctrl[`SPMS_CTRL_MASTER_SELECT_BIT] & ~pin_in.slave_sel_n_i;
    assign clock_idle_level   = s_ff.ctrl[`SPMS_CTRL_CLOCK_IDLE_LEVEL];
    assign clock_phase_sel   = s_ff.ctrl[`SPMS_CTRL_CLOCK_PHASE_SEL];
    assign lsb    = s_ff.ctrl[`SPMS_CTRL_ORD];
    assign forced = mst & ~s_ff.dir[`SPMS_DIR_SS] & ~pin_in.slave_sel_n_i;
    // rate bits only reach the master generator
    assign half   = half_of({s_ff.dbl, s_ff.ctrl[`SPMS_CTRL_RATE_H],
                             s_ff.ctrl[`SPMS_CTRL_RATE_L]});

    // clock edges: generated in master, detected on the pin in slave
    assign m_tick = mst & ~forced & (s_ff.phase != spms_pkg::SPMS_PH_IDLE) & (s_ff.div == 7'h00);
    assign s_edge = slv & (pin_in.sck_i != s_ff.sck_prev);
    assign lead   = m_tick ? (s_ff.phase == spms_pkg::SPMS_PH_LEAD)
                           : (s_edge & (pin_in.sck_i != clock_idle_level));
    assign trail  = m_tick ? (s_ff.phase == spms_pkg::SPMS_PH_TRAIL)
                           : (s_edge & (pin_in.sck_i == clock_idle_level));
    assign sample = clock_phase_sel ? trail : lead;
    assign setup  = clock_phase_sel ? (lead & (s_ff.cnt != 4'h0)) : trail;
    assign last   = trail & (s_ff.cnt == `SPMS_BIT_LAST);
    assign rx_in  = mst ? pin_in.miso_i : pin_in.mosi_i;
    // receive shift with bit order
    assign rx_next = !sample ? s_ff.rx_sh
                   : (lsb ? {rx_in, s_ff.rx_sh[7:1]} : {s_ff.rx_sh[6:0], rx_in});

    // apb decode: answer one cycle into the access phase
    assign issue    = psel & penable & ~s_ff.pready;
    assign acc      = psel & penable & s_ff.pready;
    assign sel_ctrl = (paddr == ADDR_W'(`SPMS_OFF_CTRL));
    assign sel_stat = (paddr == ADDR_W'(`SPMS_OFF_STAT));
    assign sel_data = (paddr == ADDR_W'(`SPMS_OFF_DATA));
    assign sel_dir  = (paddr == ADDR_W'(`SPMS_OFF_PINDIR));
    assign hit      = sel_ctrl | sel_stat | sel_data | sel_dir;
    assign data_wr  = acc & pwrite & sel_data;
    assign start    = data_wr & ~s_ff.xfer_on;
    assign set_done = (last & s_ff.xfer_on) | forced;
    assign clr_flags = acc & sel_data & s_ff.armed;

    // read data mux, reserved status bits zero
    always_comb begin
        rd_mux = 8'h00;
        if (sel_ctrl) begin
            rd_mux = s_ff.ctrl;
        end else if (sel_stat) begin
            rd_mux = {s_ff.done, s_ff.write_collision_flag, 5'h00, s_ff.dbl};
        end else if (sel_data) begin
            rd_mux = s_ff.rx_buf;
        end else if (sel_dir) begin
            rd_mux = {3'h0, s_ff.dir};
        end
    end

    // next state of the whole port
    always_comb begin
        nxt_s         = s_ff;
        nxt_s.pready  = issue;
        nxt_s.pslverr = issue & ~hit;
        if (issue) begin
            nxt_s.prdata = {24'h000000, rd_mux};
        end
        // register writes
        if (acc & pwrite & sel_ctrl) begin
            nxt_s.ctrl = pwdata[7:0];
        end
        if (acc & pwrite & sel_stat) begin
            nxt_s.dbl = pwdata[`SPMS_STAT_DBL];
        end
        if (acc & pwrite & sel_dir) begin
            nxt_s.dir = pwdata[4:0];
        end
        // status read with a flag set arms the clear
        if (acc & ~pwrite & sel_stat & (s_ff.done | s_ff.write_collision_flag)) begin
            nxt_s.armed = 1'b1;
        end
        if (clr_flags) begin
            nxt_s.armed = 1'b0;
        end
        // collision: data write while a byte is moving
        nxt_s.write_collision_flag = (s_ff.write_collision_flag & ~clr_flags) | (data_wr & s_ff.xfer_on);
        // done: set wins over vector and sequence clears
        // a lost set would hide a finished byte from polling software
        nxt_s.done = (s_ff.done & ~clr_flags & ~irq_vector_taken) | set_done;
        nxt_s.sck_prev = pin_in.sck_i;
        // serial engine
        nxt_s.rx_sh = rx_next;
        if (setup) begin
            nxt_s.tx_sh = lsb ? {1'b0, s_ff.tx_sh[7:1]} : {s_ff.tx_sh[6:0], 1'b0};
        end
        if (mst & ~forced) begin
            if (m_tick) begin
                nxt_s.div     = half;
                nxt_s.sck_lvl = ~s_ff.sck_lvl;
                nxt_s.phase   = lead ? spms_pkg::SPMS_PH_TRAIL : spms_pkg::SPMS_PH_LEAD;
            end else if (s_ff.phase != spms_pkg::SPMS_PH_IDLE) begin
                nxt_s.div = s_ff.div - 7'h01;
            end else begin
                nxt_s.sck_lvl = clock_idle_level;
            end
        end else if (slv & s_edge & ~s_ff.xfer_on) begin
            nxt_s.xfer_on = 1'b1;
        end
        if (trail) begin
            nxt_s.cnt = s_ff.cnt + 4'h1;
        end
        // byte end: stop, keep the received byte
        if (last) begin
            nxt_s.cnt     = 4'h0;
            nxt_s.xfer_on = 1'b0;
            nxt_s.phase   = spms_pkg::SPMS_PH_IDLE;
            nxt_s.rx_buf  = rx_next;
        end
        // data write with no byte moving loads the shifter, master starts its clock
        if (start) begin
            nxt_s.tx_sh = pwdata[7:0];
            if (mst & ~forced) begin
                nxt_s.xfer_on = 1'b1;
                nxt_s.phase   = spms_pkg::SPMS_PH_LEAD;
                nxt_s.div     = half;
                nxt_s.cnt     = 4'h0;
                nxt_s.sck_lvl = clock_idle_level;
            end
        end
        // another master pulls select: drop to slave
        // sck and mosi follow the cleared master bit and let go of the wires
        if (forced) begin
            nxt_s.ctrl[`SPMS_CTRL_MASTER_SELECT_BIT] = 1'b0;
            nxt_s.phase   = spms_pkg::SPMS_PH_IDLE;
            nxt_s.xfer_on = 1'b0;
            nxt_s.cnt     = 4'h0;
        end
        // slave deselected or port off: reset send and receive logic
        if (~en | (~s_ff.ctrl[`SPMS_CTRL_MASTER_SELECT_BIT] & pin_in.slave_sel_n_i)) begin
            nxt_s.cnt     = 4'h0;
            nxt_s.rx_sh   = 8'h00;
            nxt_s.xfer_on = 1'b0;
            nxt_s.phase   = spms_pkg::SPMS_PH_IDLE;
        end
        // interrupt request
        nxt_s.irq = nxt_s.ctrl[`SPMS_CTRL_IE] & nxt_s.done & global_irq_en;
        // pin drive from the next state
        nxt_s.pins.sck_o     = nxt_s.sck_lvl;
        nxt_s.pins.mosi_o    = lsb ? nxt_s.tx_sh[0] : nxt_s.tx_sh[7];
        nxt_s.pins.miso_o    = lsb ? nxt_s.tx_sh[0] : nxt_s.tx_sh[7];
        nxt_s.pins.sck_oe_n  = ~(nxt_s.ctrl[`SPMS_CTRL_EN] & nxt_s.ctrl[`SPMS_CTRL_MASTER_SELECT_BIT]
                                 & nxt_s.dir[`SPMS_DIR_SCK]);
        nxt_s.pins.mosi_oe_n = ~(nxt_s.ctrl[`SPMS_CTRL_EN] & nxt_s.ctrl[`SPMS_CTRL_MASTER_SELECT_BIT]
                                 & nxt_s.dir[`SPMS_DIR_MOSI]);
        nxt_s.pins.miso_oe_n = ~(nxt_s.ctrl[`SPMS_CTRL_EN] & ~nxt_s.ctrl[`SPMS_CTRL_MASTER_SELECT_BIT]
                                 & ~pin_in.slave_sel_n_i & nxt_s.dir[`SPMS_DIR_MISO]);
        nxt_s.pins.slave_sel_n_o  = nxt_s.dir[`SPMS_DIR_SSLVL];
        nxt_s.pins.slave_sel_oe_n = ~(nxt_s.dir[`SPMS_DIR_SS]
                                      & ~(nxt_s.ctrl[`SPMS_CTRL_EN]
                                          & ~nxt_s.ctrl[`SPMS_CTRL_MASTER_SELECT_BIT]));
    end

    // state register
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_ff                     <= '0;
            s_ff.ctrl                <= `SPMS_CTRL_RST;
            s_ff.dir                 <= `SPMS_DIR_RST;
            s_ff.phase               <= spms_pkg::SPMS_PH_IDLE;
            s_ff.pins.sck_oe_n       <= 1'b1;
            s_ff.pins.mosi_oe_n      <= 1'b1;
            s_ff.pins.miso_oe_n      <= 1'b1;
            s_ff.pins.slave_sel_oe_n <= 1'b1;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // outputs straight from the state register
    assign prdata  = s_ff.prdata;
    assign pready  = s_ff.pready;
    assign pslverr = s_ff.pslverr;
    assign irq_req = s_ff.irq;
    assign pin_out = s_ff.pins;

    // checks on the port's own behaviour
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    chk_irq_gate: assert property (
        irq_req == (s_ff.ctrl[`SPMS_CTRL_IE] && s_ff.done && $past(global_irq_en))
    ) else $error("interrupt request does not follow enable and flag");

    chk_force_slave: assert property (
        forced |=> !s_ff.ctrl[`SPMS_CTRL_MASTER_SELECT_BIT] && s_ff.phase == spms_pkg::SPMS_PH_IDLE
            ##1 pin_out.sck_oe_n && pin_out.mosi_oe_n
    ) else $error("master not dropped to slave on select low");

    chk_force_done: assert property (
        forced |=> s_ff.done
    ) else $error("forced slave did not set done flag");

    chk_slave_drop: assert property (
        en && !s_ff.ctrl[`SPMS_CTRL_MASTER_SELECT_BIT] && pin_in.slave_sel_n_i
            |=> s_ff.cnt == 4'h0 && s_ff.rx_sh == 8'h00 && !s_ff.xfer_on
    ) else $error("slave logic not reset on deselect");

    chk_write_collision_flag_set: assert property (
        data_wr && s_ff.xfer_on |=> s_ff.write_collision_flag && ($stable(s_ff.tx_sh) || $past(setup))
    ) else $error("write during transfer not flagged");

    chk_disabled_idle: assert property (
        !en ##1 !en |-> s_ff.phase == spms_pkg::SPMS_PH_IDLE && !s_ff.xfer_on
            && pin_out.sck_oe_n && pin_out.mosi_oe_n && pin_out.miso_oe_n
    ) else $error("serial activity while port disabled");

    chk_div_count: assert property (
        mst && !forced && s_ff.phase != spms_pkg::SPMS_PH_IDLE && s_ff.div != 7'h00
            && !data_wr |=> s_ff.div == $past(s_ff.div) - 7'h01 && $stable(s_ff.sck_lvl)
    ) else $error("master clock divider miscounts");

    chk_reserved_zero: assert property (
        issue && sel_stat |=> prdata[5:1] == 5'h00 && prdata[31:8] == 24'h000000
    ) else $error("reserved status bits not zero");

    chk_flag_clear: assert property (
        clr_flags && !set_done && !(data_wr && s_ff.xfer_on)
            |=> !s_ff.done && !s_ff.write_collision_flag && !s_ff.armed
    ) else $error("status-data sequence did not clear flags");

    chk_byte_end: assert property (
        last && s_ff.xfer_on && !forced |=> s_ff.done && !s_ff.xfer_on
            && s_ff.rx_buf == $past(rx_next)
    ) else $error("byte end did not set flag and buffer");

    // pin drive, flag sources, shifter load and bus answer
    chk_miso_drive: assert property (
        !pin_out.miso_oe_n |-> s_ff.ctrl[`SPMS_CTRL_EN] && !s_ff.ctrl[`SPMS_CTRL_MASTER_SELECT_BIT]
            && s_ff.dir[`SPMS_DIR_MISO] && pin_out.sck_oe_n && pin_out.mosi_oe_n
    ) else $error("data-out driven outside selected slave operation");

    chk_done_wins: assert property (
        set_done |=> s_ff.done
    ) else $error("done flag lost against a clear");

    chk_irq_vector: assert property (
        irq_vector_taken && !set_done |=> !s_ff.done
    ) else $error("vector taken did not clear done flag");

    chk_write_collision_flag_cause: assert property (
        $rose(s_ff.write_collision_flag) |-> $past(data_wr) && $past(s_ff.xfer_on)
    ) else $error("collision flag set without a data write while busy");

    chk_idle_sck: assert property (
        mst && !forced && s_ff.phase == spms_pkg::SPMS_PH_IDLE
            |=> pin_out.sck_o == $past(clock_idle_level)
    ) else $error("master clock not at idle level between bytes");

    chk_start_load: assert property (
        start |=> s_ff.tx_sh == $past(pwdata[7:0])
    ) else $error("data write did not load the shifter");

    chk_ready_pulse: assert property (
        pready |=> !pready && !pslverr
    ) else $error("bus answer stands longer than one cycle");

    cov_master_byte: cover property (mst && last);
    cov_slave_byte: cover property (slv && last);
    cov_forced: cover property (forced);
    cov_collision: cover property (data_wr && s_ff.xfer_on);

endmodule : spms_port

// ---- bench/spms_peer.sv ----
// serial peer device answering the port while the port is master
`timescale 1ns/1ps
module spms_peer (
    // serial wires
    input  wire logic       sck,
    input  wire logic       mosi,
    output logic            miso,
    // frame setup from the bench
    input  wire logic       clock_idle_level,
    input  wire logic       clock_phase_sel,
    input  wire logic       lsb,
    input  wire logic       load,
    input  wire logic [7:0] tx_byte,
    output logic [7:0]      rx_byte,
    output logic [3:0]      n_bits
);
    logic [7:0] tx_sh;
    logic       fresh;

    // idle until loaded
    initial begin
        n_bits = 4'h8;
        miso = 1'b0;
        rx_byte = 8'h00;
        tx_sh = 8'h00;
        fresh = 1'b0;
    end

    // load presents the first bit ahead of any clock edge
    always @(posedge load) begin
        tx_sh = tx_byte;
        rx_byte = 8'h00;
        n_bits = 4'h0;
        fresh = clock_phase_sel;
        miso = lsb ? tx_byte[0] : tx_byte[7];
    end

    // sample and setup on opposite edges of the serial clock
    always @(sck) begin
        if (n_bits < 4'h8) begin
            if ((sck != clock_idle_level) != clock_phase_sel) begin
                rx_byte = lsb ? {mosi, rx_byte[7:1]} : {rx_byte[6:0], mosi};
                n_bits = n_bits + 4'h1;
                if (n_bits == 4'h8) miso = ~miso; // last bit taken, line still driven, shows inverse
            end else begin
                if (!fresh) tx_sh = lsb ? tx_sh >> 1 : tx_sh << 1;
                fresh = 1'b0;
                miso = lsb ? tx_sh[0] : tx_sh[7];
            end
        end
    end
endmodule : spms_peer

// ---- bench/tb_top.sv ----
// bench for the serial port: apb register access, master and slave transfers
`timescale 1ns/1ps
`include "spms_map.svh"
module tb_top;
    localparam logic [7:0] a_ctrl = `SPMS_OFF_CTRL;
    localparam logic [7:0] a_stat = `SPMS_OFF_STAT;
    localparam logic [7:0] a_data = `SPMS_OFF_DATA;
    localparam logic [7:0] a_dir  = `SPMS_OFF_PINDIR;
    logic        core_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic        pready, pslverr, irq_req;
    logic        global_irq_en = 1'b0, irq_vector_taken = 1'b0;
    logic        m_sck = 1'b0, m_mosi = 1'b0, m_ss = 1'b1, p_miso;
    logic        clock_idle_level = 1'b0, clock_phase_sel = 1'b0, lsb = 1'b0, load = 1'b0;
    logic [7:0]  p_tx = 8'h00, p_rx;
    logic [3:0]  p_n;
    wire         sck_w, mosi_w, miso_w, ss_w;
    int          err_count = 0, comparisons = 0;
    spms_pkg::spms_pin_in_t  pin_in;
    spms_pkg::spms_pin_out_t pin_out;

    // wire levels from the port's enables, bench and peer drive otherwise
    assign sck_w  = !pin_out.sck_oe_n ? pin_out.sck_o : m_sck;
    assign mosi_w = !pin_out.mosi_oe_n ? pin_out.mosi_o : m_mosi;
    assign miso_w = !pin_out.miso_oe_n ? pin_out.miso_o : p_miso;
    assign ss_w   = !pin_out.slave_sel_oe_n ? pin_out.slave_sel_n_o : m_ss;
    assign pin_in = {sck_w, mosi_w, miso_w, ss_w};

    spms_port #(.ADDR_W(8)) dut_u (.core_clk(core_clk), .sys_rst(sys_rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .global_irq_en(global_irq_en), .irq_vector_taken(irq_vector_taken),
        .irq_req(irq_req), .pin_in(pin_in), .pin_out(pin_out));
    spms_peer peer_u (.sck(sck_w), .mosi(mosi_w), .miso(p_miso), .clock_idle_level(clock_idle_level), .clock_phase_sel(clock_phase_sel),
        .lsb(lsb), .load(load), .tx_byte(p_tx), .rx_byte(p_rx), .n_bits(p_n));

    // 100 MHz clock
    always #5 core_clk = ~core_clk;

    task automatic end_sim;
        if (err_count == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : chk

    task automatic clks(input int n);
        repeat (n) @(posedge core_clk);
    endtask : clks

    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        clks(1);
        penable <= 1'b1;
        // wait for the answer; only the watchdog ends a hung wait
        do begin
            clks(1);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        clks(1);
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, {24'h0, d}, r, e);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] r);
        logic e;
        apb(1'b0, a, 32'h0, r, e);
    endtask : rd

    function automatic int divof(input logic [2:0] c);
        case (c)
            3'h0: return 4;
            3'h1: return 16;
            3'h2: return 64;
            3'h3: return 128;
            3'h4: return 2;
            3'h5: return 8;
            3'h6: return 32;
            default: return 64;
        endcase
    endfunction : divof

    // configure master mode, load the peer and send one byte
    task automatic start_m(input logic [7:0] c, input logic d, input logic [7:0] tx,
                           input logic [7:0] ptx);
        clock_idle_level <= c[`SPMS_CTRL_CLOCK_IDLE_LEVEL];
        clock_phase_sel <= c[`SPMS_CTRL_CLOCK_PHASE_SEL];
        lsb <= c[`SPMS_CTRL_ORD];
        m_sck <= c[`SPMS_CTRL_CLOCK_IDLE_LEVEL];
        wr(a_ctrl, c);
        wr(a_stat, {7'h00, d});
        wr(a_dir, 8'h03);
        p_tx <= ptx;
        load <= 1'b1;
        clks(1);
        load <= 1'b0;
        wr(a_data, tx);
    endtask : start_m

    // master byte with clock edge count and spacing measured
    task automatic run_m(input logic [7:0] c, input logic d, input logic [7:0] tx,
                         input logic [7:0] ptx);
        int   n, t, f, l;
        logic s;
        start_m(c, d, tx, ptx);
        s = sck_w;
        n = 0;
        t = 0;
        f = 0;
        l = 0;
        while (t < 16 && n < 3000) begin
            clks(1);
            n++;
            if (sck_w !== s) begin
                s = sck_w;
                if (t == 0) f = n;
                l = n;
                t++;
            end
        end
        clks(10);
        chk(t, 16);
        chk(l - f, 15 * divof({d, c[1:0]}) / 2);
        chk(sck_w, c[`SPMS_CTRL_CLOCK_IDLE_LEVEL]);
        chk(p_rx, tx);
        chk(p_n, 4'h8);
    endtask : run_m

    // status read then data read clears the flags
    task automatic done_rd(input logic [7:0] st, input logic [7:0] dat);
        logic [31:0] r;
        rd(a_stat, r);
        chk(r, {24'h0, st});
        rd(a_data, r);
        chk(r, {24'h0, dat});
        rd(a_stat, r);
        chk(r, {24'h0, st & 8'h01});
    endtask : done_rd

    // external master byte, mode 0, msb first, half period of four cycles
    task automatic ext(input logic [7:0] b, input int nb, output logic [7:0] g);
        g = 8'h00;
        for (int i = 0; i < nb; i++) begin
            m_mosi <= b[7-i];
            clks(4);
            g = {g[6:0], miso_w};
            m_sck <= 1'b1;
            clks(4);
            m_sck <= 1'b0;
        end
        clks(4);
        m_mosi <= ~m_mosi;
    endtask : ext

    task automatic t_regs;
        logic [31:0] r;
        logic        e;
        rd(a_ctrl, r);
        chk(r, 32'h0);
        wr(a_ctrl, 8'h2F);
        rd(a_ctrl, r);
        chk(r, 32'h2F);
        wr(a_stat, 8'hFF);
        rd(a_stat, r);
        chk(r, 32'h01);
        apb(1'b0, 8'h3C, 32'h0, r, e);
        chk(r, 32'h0);
        chk({31'h0, e}, 32'h1);
        wr(a_stat, 8'h00);
        wr(a_ctrl, 8'h10);
        wr(a_data, 8'h55);
        clks(300);
        chk(pin_out.sck_oe_n, 1'b1);
        rd(a_stat, r);
        chk(r, 32'h0);
    endtask : t_regs

    task automatic t_rates;
        for (int i = 0; i < 8; i++) begin
            run_m({6'h14, i[1:0]}, i[2], 8'h96 + i[7:0], 8'h69);
            done_rd({7'h40, i[2]}, 8'h69);
        end
    endtask : t_rates

    task automatic t_modes;
        for (int i = 0; i < 8; i++) begin
            run_m({2'b01, i[2], 1'b1, i[1:0], 2'b00}, 1'b0, 8'hB1, 8'h4E);
            done_rd(8'h80, 8'h4E);
        end
    endtask : t_modes

    task automatic t_coll;
        start_m(8'h53, 1'b0, 8'h0F, 8'hF0);
        wr(a_data, 8'hFF);
        clks(1100);
        done_rd(8'hC0, 8'hF0);
        chk(p_rx, 8'h0F);
    endtask : t_coll

    task automatic t_irq;
        logic [31:0] r;
        global_irq_en <= 1'b1;
        run_m(8'hD0, 1'b0, 8'h11, 8'h22);
        chk(irq_req, 1'b1);
        irq_vector_taken <= 1'b1;
        clks(1);
        irq_vector_taken <= 1'b0;
        clks(3);
        chk(irq_req, 1'b0);
        rd(a_stat, r);
        chk(r, 32'h0);
        global_irq_en <= 1'b0;
        run_m(8'hD0, 1'b0, 8'h33, 8'h44);
        chk(irq_req, 1'b0);
        done_rd(8'h80, 8'h44);
    endtask : t_irq

    task automatic t_force;
        logic [31:0] r;
        global_irq_en <= 1'b1;
        wr(a_ctrl, 8'hD0);
        wr(a_dir, 8'h03);
        m_ss <= 1'b0;
        clks(6);
        rd(a_ctrl, r);
        chk(r, 32'hC0);
        chk({pin_out.sck_oe_n, pin_out.mosi_oe_n}, 2'b11);
        chk(irq_req, 1'b1);
        m_ss <= 1'b1;
        global_irq_en <= 1'b0;
        done_rd(8'h80, 8'h44);
        wr(a_ctrl, 8'h50);
        wr(a_dir, 8'h07);
        clks(6);
        chk(ss_w, 1'b0);
        rd(a_ctrl, r);
        chk(r, 32'h50);
        rd(a_stat, r);
        chk(r, 32'h0);
        wr(a_dir, 8'h00);
    endtask : t_force

    task automatic t_slave;
        logic [7:0] g;
        m_sck <= 1'b0;
        wr(a_ctrl, 8'h43);
        wr(a_dir, 8'h08);
        wr(a_data, 8'hA5);
        m_ss <= 1'b0;
        clks(4);
        chk({pin_out.miso_oe_n, pin_out.sck_oe_n, pin_out.mosi_oe_n}, 3'b011);
        ext(8'h3C, 8, g);
        chk(g, 8'hA5);
        m_ss <= 1'b1;
        clks(4);
        chk(pin_out.miso_oe_n, 1'b1);
        done_rd(8'h80, 8'h3C);
        m_ss <= 1'b0;
        ext(8'hFF, 3, g);
        m_ss <= 1'b1;
        clks(4);
        m_ss <= 1'b0;
        clks(4);
        ext(8'h5A, 8, g);
        m_ss <= 1'b1;
        clks(4);
        done_rd(8'h80, 8'h5A);
    endtask : t_slave

    // main sequence
    initial begin
        clks(20);
        sys_rst <= 1'b0;
        clks(1);
        t_regs;
        t_rates;
        t_modes;
        t_coll;
        t_irq;
        t_force;
        t_slave;
        end_sim;
    end

    // watchdog well beyond the expected run length
    initial begin
        clks(40000);
        err_count++;
        end_sim;
    end
endmodule : tb_top
